// [logic/tmc_pkg.sv]
// Shared constants, types and register map for the 16-bit timer control block
// Summary of operation
// - Control B bit 5 reads zero, ignores writes
// - Mode code is B[4:3] above A[1:0]
// - Code 0 normal; 1-3 phase PWM 8/9/10
// - Codes 4 and C clear at compare A
// - Codes 5-7 fast PWM 8/9/10 bit top
// - Code 8/9 phase-frequency PWM, capture/compare A top
// - Code A/B phase PWM, capture/compare A top
// - D reserved; E/F fast PWM capture/compare A
// - Select 0 stops; 1-5 divide 1..1024
// - Select 6/7 count external pin fall/rise
// - External pin counts even when driven out
// - Force bits act only in non-PWM modes
// - Force applies compare action from current mode
// - Force sets no event, never clears counter
// - Force bits are strobes, read zero
// - Control C bits 4:0 read-only zero
// - Counter readable and writable as two bytes
// - One shared temporary high byte register
// - Counter write blocks next tick's matches
// - Output mode 0 off,1 toggle,2 clear,3 set
`default_nettype none
package tmc_pkg;
	// Register indices; byte address is index times four
	localparam logic [7:0] IDX_WAVE_CTRL  = 8'h80;
	localparam logic [7:0] IDX_MODE_CLOCK = 8'h81;
	localparam logic [7:0] IDX_FORCE      = 8'h82;
	localparam logic [7:0] IDX_COUNT_LOW  = 8'h84;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'h85;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] MODE_CLOCK_WMASK = 8'hdf;
	localparam logic [7:0] FORCE_READ     = 8'h00;
	localparam int unsigned RES_BIT       = 32'h5;
	localparam int unsigned FORCE_LO      = 32'h5;
	// Waveform mode codes
	localparam logic [3:0] WM_NORMAL     = 4'h0;
	localparam logic [3:0] WM_PC8        = 4'h1;
	localparam logic [3:0] WM_PC9        = 4'h2;
	localparam logic [3:0] WM_PC10       = 4'h3;
	localparam logic [3:0] WM_CTC_A      = 4'h4;
	localparam logic [3:0] WM_FAST8      = 4'h5;
	localparam logic [3:0] WM_FAST9      = 4'h6;
	localparam logic [3:0] WM_FAST10     = 4'h7;
	localparam logic [3:0] WM_PFC_CAP    = 4'h8;
	localparam logic [3:0] WM_PFC_A      = 4'h9;
	localparam logic [3:0] WM_PC_CAP     = 4'ha;
	localparam logic [3:0] WM_PC_A       = 4'hb;
	localparam logic [3:0] WM_CTC_A2     = 4'hc;
	localparam logic [3:0] WM_RESERVED   = 4'hd;
	localparam logic [3:0] WM_FAST_CAP   = 4'he;
	localparam logic [3:0] WM_FAST_A     = 4'hf;
	// Fixed tops
	localparam logic [15:0] TOP_8BIT  = 16'h00ff;
	localparam logic [15:0] TOP_9BIT  = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [15:0] TOP_MAX   = 16'hffff;
	// Clock select codes and prescaler masks
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int unsigned PRESCALE_WIDTH = 32'ha;
	localparam logic [9:0] MASK_DIV8    = 10'h007;
	localparam logic [9:0] MASK_DIV64   = 10'h03f;
	localparam logic [9:0] MASK_DIV256  = 10'h0ff;
	localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
	// Compare output modes
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR  = 2'h2;
	localparam logic [1:0] OM_SET    = 2'h3;
	// Counting behaviour class
	typedef enum logic [5:0] {
		KIND_NORMAL = 6'b000001,
		KIND_CTC    = 6'b000010,
		KIND_FAST   = 6'b000100,
		KIND_PHASE  = 6'b001000,
		KIND_PHFREQ = 6'b010000,
		KIND_RESV   = 6'b100000
	} tmc_kind_e;
	// Control A layout; index 2 is channel A, 0 is channel C
	typedef struct packed {
		logic [2:0][1:0] out_mode;
		logic [1:0]      waveform_mode_lower;
	} tmc_wave_ctrl_s;
	// Control B layout
	typedef struct packed {
		logic       noise_cancel;
		logic       capture_edge;
		logic       reserved;
		logic [1:0] waveform_mode_upper;
		logic [2:0] clock_prescale_sel;
	} tmc_mode_clock_s;
	// Compare values from the compare register block, index 2 is channel A
	typedef struct packed {
		logic [2:0][15:0] value;
	} tmc_compare_s;
endpackage : tmc_pkg
`default_nettype wire

// [logic/tmc_clock_select.sv]
// Timer clock source selection: prescaler taps and external pin edges
`timescale 1ns/1ps
`default_nettype none
module tmc_clock_select (
	input  wire logic       REF_CLK,
	input  wire logic       RESET,
	input  wire logic [2:0] clock_prescale_sel,
	input  wire logic       ext_count_pin,
	output logic            tick
);
	logic [tmc_pkg::PRESCALE_WIDTH-1:0] prescale_count;
	logic                               pin_prev;

	// Free-running prescaler shared by every divided tap
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			prescale_count <= '0;
		end else begin
			prescale_count <= prescale_count + 10'h001;
		end
	end

	// Previous pin sample; the pin is read whatever its direction
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= ext_count_pin;
		end
	end

	// Tick source per clock select code
	always_comb begin
		tick = 1'b0;
		unique case (clock_prescale_sel)
			tmc_pkg::CS_STOP:     tick = 1'b0;
			tmc_pkg::CS_DIV1:     tick = 1'b1;
			tmc_pkg::CS_DIV8:     tick = (prescale_count & tmc_pkg::MASK_DIV8) == tmc_pkg::MASK_DIV8;
			tmc_pkg::CS_DIV64:    tick = (prescale_count & tmc_pkg::MASK_DIV64) == tmc_pkg::MASK_DIV64;
			tmc_pkg::CS_DIV256:   tick = (prescale_count & tmc_pkg::MASK_DIV256) == tmc_pkg::MASK_DIV256;
			tmc_pkg::CS_DIV1024:  tick = prescale_count == tmc_pkg::MASK_DIV1024;
			tmc_pkg::CS_EXT_FALL: tick = pin_prev & ~ext_count_pin;
			tmc_pkg::CS_EXT_RISE: tick = ~pin_prev & ext_count_pin;
		endcase
	end
endmodule : tmc_clock_select
`default_nettype wire

// [logic/tmc_timer.sv]
// 16-bit timer control, counter and force-compare block with Avalon-MM registers
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer (
	input  wire logic                  REF_CLK,
	input  wire logic                  RESET,
	input  wire logic [9:0]            AVS_ADDRESS,
	input  wire logic                  AVS_READ,
	input  wire logic                  AVS_WRITE,
	input  wire logic [31:0]           AVS_WRITEDATA,
	input  wire logic [3:0]            AVS_BYTEENABLE,
	output logic      [31:0]           AVS_READDATA,
	output logic                       AVS_WAITREQUEST,
	input  wire logic                  EXT_COUNT_PIN,
	input  wire tmc_pkg::tmc_compare_s COMPARE_VALUES,
	input  wire logic [15:0]           CAPTURE_VALUE,
	output logic      [15:0]           COUNT_VALUE,
	output logic                       COUNT_DOWN,
	output logic      [3:0]            WAVEFORM_MODE,
	output logic      [2:0]            COMPARE_MATCH,
	output logic      [2:0]            WAVE_OUT,
	output logic      [2:0]            WAVE_CONNECT,
	output logic      [7:0]            TEMP_HIGH,
	output logic      [1:0]            CAPTURE_CTRL
);
	tmc_pkg::tmc_wave_ctrl_s  wave_ctrl;
	tmc_pkg::tmc_mode_clock_s mode_clock;
	tmc_pkg::tmc_kind_e       kind;
	logic                     ack;
	logic                     addr_ok;
	logic [7:0]               reg_idx;
	logic                     rd_take;
	logic                     wr_take;
	logic [7:0]               wr_byte;
	logic [7:0]               rd_byte;
	logic                     count_wr;
	logic                     force_wr;
	logic [2:0]               force_vec;
	logic                     non_pwm;
	logic                     tick;
	logic                     block;
	logic [15:0]              top;
	logic [2:0]               raw_hit;

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave

	// One wait cycle per access so read data is always from a flop
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ack <= 1'b0;
		end else begin
			ack <= (AVS_READ | AVS_WRITE) & ~ack;
		end
	end

	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
	assign addr_ok  = AVS_ADDRESS[1:0] == 2'h0;
	assign reg_idx  = AVS_ADDRESS[9:2];
	assign rd_take  = AVS_READ & ~ack & addr_ok;  // First edge of a read
	assign wr_take  = AVS_WRITE & ack & addr_ok & AVS_BYTEENABLE[0];  // Accept edge
	assign wr_byte  = AVS_WRITEDATA[7:0];
	assign count_wr = wr_take & (reg_idx == tmc_pkg::IDX_COUNT_LOW);
	assign force_wr = wr_take & (reg_idx == tmc_pkg::IDX_FORCE);

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_byte = 8'h00;
		case (reg_idx)
			tmc_pkg::IDX_WAVE_CTRL:  rd_byte = wave_ctrl;
			tmc_pkg::IDX_MODE_CLOCK: rd_byte = mode_clock & tmc_pkg::MODE_CLOCK_WMASK;
			tmc_pkg::IDX_FORCE:      rd_byte = tmc_pkg::FORCE_READ;
			tmc_pkg::IDX_COUNT_LOW:  rd_byte = COUNT_VALUE[7:0];
			tmc_pkg::IDX_COUNT_HIGH: rd_byte = TEMP_HIGH;
			default:                 rd_byte = 8'h00;
		endcase
	end

	// Read data captured on the first edge, held for the accept edge;
	// unaligned reads load zero so stale data never leaks out
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ && !ack) begin
			AVS_READDATA <= {24'h00_0000, addr_ok ? rd_byte : 8'h00};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers

	// Control A: output modes and lower mode bits
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			wave_ctrl <= tmc_pkg::REG_RESET;
		end else if (wr_take && reg_idx == tmc_pkg::IDX_WAVE_CTRL) begin
			wave_ctrl <= wr_byte;
		end
	end

	// Control B: reserved bit masked so it never changes
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			mode_clock <= tmc_pkg::REG_RESET;
		end else if (wr_take && reg_idx == tmc_pkg::IDX_MODE_CLOCK) begin
			mode_clock <= wr_byte & tmc_pkg::MODE_CLOCK_WMASK;
		end
	end

	assign WAVEFORM_MODE = {mode_clock.waveform_mode_upper,
		wave_ctrl.waveform_mode_lower};
	assign CAPTURE_CTRL  = {mode_clock.noise_cancel, mode_clock.capture_edge};

	// Shared temporary byte: high write stores, low read latches
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			TEMP_HIGH <= tmc_pkg::REG_RESET;
		end else if (wr_take && reg_idx == tmc_pkg::IDX_COUNT_HIGH) begin
			TEMP_HIGH <= wr_byte;
		end else if (rd_take && reg_idx == tmc_pkg::IDX_COUNT_LOW) begin
			TEMP_HIGH <= COUNT_VALUE[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode decode

	// Class and top value for each code
	always_comb begin
		kind = tmc_pkg::KIND_NORMAL;
		top  = tmc_pkg::TOP_MAX;
		unique case (WAVEFORM_MODE)
			tmc_pkg::WM_NORMAL: begin
				kind = tmc_pkg::KIND_NORMAL;
				top  = tmc_pkg::TOP_MAX;
			end
			tmc_pkg::WM_PC8: begin
				kind = tmc_pkg::KIND_PHASE;
				top  = tmc_pkg::TOP_8BIT;
			end
			tmc_pkg::WM_PC9: begin
				kind = tmc_pkg::KIND_PHASE;
				top  = tmc_pkg::TOP_9BIT;
			end
			tmc_pkg::WM_PC10: begin
				kind = tmc_pkg::KIND_PHASE;
				top  = tmc_pkg::TOP_10BIT;
			end
			tmc_pkg::WM_CTC_A, tmc_pkg::WM_CTC_A2: begin
				kind = tmc_pkg::KIND_CTC;
				top  = COMPARE_VALUES.value[2];
			end
			tmc_pkg::WM_FAST8: begin
				kind = tmc_pkg::KIND_FAST;
				top  = tmc_pkg::TOP_8BIT;
			end
			tmc_pkg::WM_FAST9: begin
				kind = tmc_pkg::KIND_FAST;
				top  = tmc_pkg::TOP_9BIT;
			end
			tmc_pkg::WM_FAST10: begin
				kind = tmc_pkg::KIND_FAST;
				top  = tmc_pkg::TOP_10BIT;
			end
			tmc_pkg::WM_PFC_CAP: begin
				kind = tmc_pkg::KIND_PHFREQ;
				top  = CAPTURE_VALUE;
			end
			tmc_pkg::WM_PFC_A: begin
				kind = tmc_pkg::KIND_PHFREQ;
				top  = COMPARE_VALUES.value[2];
			end
			// Phase correct with capture or compare A top
			tmc_pkg::WM_PC_CAP: begin
				kind = tmc_pkg::KIND_PHASE;
				top  = CAPTURE_VALUE;
			end
			tmc_pkg::WM_PC_A: begin
				kind = tmc_pkg::KIND_PHASE;
				top  = COMPARE_VALUES.value[2];
			end
			// Reserved code holds the counter
			tmc_pkg::WM_RESERVED: begin
				kind = tmc_pkg::KIND_RESV;
				top  = tmc_pkg::TOP_MAX;
			end
			tmc_pkg::WM_FAST_CAP: begin
				kind = tmc_pkg::KIND_FAST;
				top  = CAPTURE_VALUE;
			end
			tmc_pkg::WM_FAST_A: begin
				kind = tmc_pkg::KIND_FAST;
				top  = COMPARE_VALUES.value[2];
			end
		endcase
	end

	assign non_pwm = (kind == tmc_pkg::KIND_NORMAL) || (kind == tmc_pkg::KIND_CTC);

	// Force strobes live one cycle only and need a non-PWM mode
	assign force_vec = (force_wr && non_pwm) ? wr_byte[tmc_pkg::FORCE_LO +: 3] : 3'h0;

	////////////////////////////////////////////////////////////////////////////
	// Counter

	tmc_clock_select u_clock_select (
		.REF_CLK            (REF_CLK),
		.RESET              (RESET),
		.clock_prescale_sel (mode_clock.clock_prescale_sel),
		.ext_count_pin      (EXT_COUNT_PIN),
		.tick               (tick)
	);

	// Software write wins over counting; phase modes run up then down
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			COUNT_VALUE <= 16'h0000;
			COUNT_DOWN  <= 1'b0;
		end else if (count_wr) begin
			COUNT_VALUE <= {TEMP_HIGH, wr_byte};
		end else if (tick) begin
			unique case (kind)
				tmc_pkg::KIND_NORMAL: COUNT_VALUE <= COUNT_VALUE + 16'h0001;
				// Clear only on a real compare A match, never a forced one
				tmc_pkg::KIND_CTC: begin
					if (COUNT_VALUE == top && !block) begin
						COUNT_VALUE <= 16'h0000;
					end else begin
						COUNT_VALUE <= COUNT_VALUE + 16'h0001;
					end
				end
				tmc_pkg::KIND_FAST: begin
					if (COUNT_VALUE >= top) begin
						COUNT_VALUE <= 16'h0000;
					end else begin
						COUNT_VALUE <= COUNT_VALUE + 16'h0001;
					end
				end
				tmc_pkg::KIND_PHASE, tmc_pkg::KIND_PHFREQ: begin
					if (!COUNT_DOWN && COUNT_VALUE >= top) begin
						COUNT_DOWN  <= 1'b1;
						COUNT_VALUE <= COUNT_VALUE - 16'h0001;
					end else if (COUNT_DOWN && COUNT_VALUE == 16'h0000) begin
						COUNT_DOWN  <= 1'b0;
						COUNT_VALUE <= COUNT_VALUE + 16'h0001;
					end else if (COUNT_DOWN) begin
						COUNT_VALUE <= COUNT_VALUE - 16'h0001;
					end else begin
						COUNT_VALUE <= COUNT_VALUE + 16'h0001;
					end
				end
				tmc_pkg::KIND_RESV: COUNT_VALUE <= COUNT_VALUE;
			endcase
		end
	end

	// Block armed by a counter write, spent on the next tick; arming wins
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			block <= 1'b0;
		end else if (count_wr) begin
			block <= 1'b1;
		end else if (tick) begin
			block <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare channels, index 2 = A, 1 = B, 0 = C

	for (genvar i = 0; i < 3; i++) begin : g_chan
		logic [1:0] om;
		assign om = wave_ctrl.out_mode[i];
		assign raw_hit[i] = tick & ~block & ~count_wr &
			(COUNT_VALUE == COMPARE_VALUES.value[i]);
		assign WAVE_CONNECT[i] = om != tmc_pkg::OM_OFF;

		// Event pulse for the flag logic; forced compares never reach it
		always_ff @(posedge REF_CLK) begin
			if (RESET) begin
				COMPARE_MATCH[i] <= 1'b0;
			end else begin
				COMPARE_MATCH[i] <= raw_hit[i];
			end
		end

		// Waveform bit; the mode bits of the same cycle decide a forced effect
		always_ff @(posedge REF_CLK) begin
			if (RESET) begin
				WAVE_OUT[i] <= 1'b0;
			end else if (non_pwm) begin
				if (raw_hit[i] || force_vec[i]) begin
					unique case (om)
						tmc_pkg::OM_OFF:    WAVE_OUT[i] <= WAVE_OUT[i];
						tmc_pkg::OM_TOGGLE: WAVE_OUT[i] <= ~WAVE_OUT[i];
						tmc_pkg::OM_CLEAR:  WAVE_OUT[i] <= 1'b0;
						tmc_pkg::OM_SET:    WAVE_OUT[i] <= 1'b1;
					endcase
				end
			end else if (raw_hit[i] && om[1]) begin
				// PWM: clear mode drops on an up match, rises on a down match
				WAVE_OUT[i] <= om[0] ^ COUNT_DOWN;
			end else if (tick && !count_wr && kind == tmc_pkg::KIND_FAST &&
				COUNT_VALUE >= top && om[1]) begin
				WAVE_OUT[i] <= ~om[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_res_bit_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
		(rd_take && reg_idx == tmc_pkg::IDX_MODE_CLOCK) |=> !AVS_READDATA[tmc_pkg::RES_BIT])
		else $error("reserved control bit read as one");

	a_force_reads_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
		(rd_take && reg_idx == tmc_pkg::IDX_FORCE) |=> AVS_READDATA == 32'h0000_0000)
		else $error("force register read not zero");

	a_stop_holds: assert property (@(posedge REF_CLK) disable iff (RESET)
		(mode_clock.clock_prescale_sel == tmc_pkg::CS_STOP && !count_wr)
		|=> $stable(COUNT_VALUE))
		else $error("counter moved while stopped");

	a_div1_counts: assert property (@(posedge REF_CLK) disable iff (RESET)
		(mode_clock.clock_prescale_sel == tmc_pkg::CS_DIV1 &&
		kind == tmc_pkg::KIND_NORMAL && !count_wr)
		|=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001)
		else $error("normal undivided count did not step");

	a_ext_rise_counts: assert property (@(posedge REF_CLK) disable iff (RESET)
		(mode_clock.clock_prescale_sel == tmc_pkg::CS_EXT_RISE &&
		kind == tmc_pkg::KIND_NORMAL && !count_wr && $rose(EXT_COUNT_PIN))
		|=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001)
		else $error("rising pin edge not counted");

	a_force_sets_a: assert property (@(posedge REF_CLK) disable iff (RESET)
		(force_vec[2] && wave_ctrl.out_mode[2] == tmc_pkg::OM_SET) |=> WAVE_OUT[2])
		else $error("forced set on channel A missed");

	a_force_no_event: assert property (@(posedge REF_CLK) disable iff (RESET)
		(|force_vec && !tick) |=> COMPARE_MATCH == 3'h0)
		else $error("forced compare raised an event");

	a_pwm_force_off: assert property (@(posedge REF_CLK) disable iff (RESET)
		(force_wr && !non_pwm && !tick) |=> $stable(WAVE_OUT))
		else $error("force acted in a PWM mode");

	a_write_blocks: assert property (@(posedge REF_CLK) disable iff (RESET)
		(block && tick && !count_wr) |=> COMPARE_MATCH == 3'h0)
		else $error("match seen on blocked tick");

	a_temp_latch: assert property (@(posedge REF_CLK) disable iff (RESET)
		(rd_take && reg_idx == tmc_pkg::IDX_COUNT_LOW)
		|=> TEMP_HIGH == $past(COUNT_VALUE[15:8]))
		else $error("low read did not latch high byte");

	a_count_commit: assert property (@(posedge REF_CLK) disable iff (RESET)
		count_wr |=> COUNT_VALUE == {$past(TEMP_HIGH), $past(AVS_WRITEDATA[7:0])})
		else $error("low write did not commit both bytes");
endmodule : tmc_timer
`default_nettype wire

// [tb/tmc_far_side.sv]
// Far-side model: external count pin and compare and capture sources
`timescale 1ns/1ps
`default_nettype none
module tmc_far_side (
	input  wire logic                  ref_clk,
	input  wire logic [2:0]            wave_out,
	output var  logic                  count_pin,
	output var  tmc_pkg::tmc_compare_s compare_values,
	output var  logic [15:0]           capture_value
);
	// Fixed values; A doubles as the clear-on-match top
	initial begin
		count_pin = 1'h0;
		compare_values.value[2] = 16'h0040;
		compare_values.value[1] = 16'h0020;
		compare_values.value[0] = 16'h0030;
		capture_value = 16'h0030;
	end
	////////////////////////////////////////
	// Pin driven like software toggling an output; still has to count
	task automatic pulse_pin(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (3) @(posedge ref_clk);
			count_pin <= 1'h1;
			repeat (3) @(posedge ref_clk);
			count_pin <= 1'h0;
		end
	endtask : pulse_pin
endmodule : tmc_far_side
`default_nettype wire

// [tb/tmc_timer_test.sv]
// Self-checking bench for the 16-bit timer control block
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_test;
	logic                  ref_clk = 1'h0;
	logic                  reset = 1'h1;
	logic [9:0]            avs_address = 10'h000;
	logic                  avs_read = 1'h0;
	logic                  avs_write = 1'h0;
	logic [31:0]           avs_writedata = 32'h0;
	logic [31:0]           avs_readdata;
	logic                  avs_waitrequest;
	logic                  count_pin;
	tmc_pkg::tmc_compare_s compare_values;
	logic [15:0]           capture_value;
	logic [15:0]           count_value;
	logic                  count_down;
	logic [2:0]            compare_match;
	logic [2:0]            wave_out;
	logic [2:0]            wave_connect;
	logic [7:0]            temp_high;
	logic [1:0]            capture_ctrl;
	logic [3:0]            waveform_mode;
	int                    err_count = 0;
	int                    n_compared = 0;
	int                    hits[3] = '{0, 0, 0};

	tmc_timer u_dut (.REF_CLK(ref_clk), .RESET(reset), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_BYTEENABLE(4'hf), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .EXT_COUNT_PIN(count_pin),
		.COMPARE_VALUES(compare_values), .CAPTURE_VALUE(capture_value),
		.COUNT_VALUE(count_value), .COUNT_DOWN(count_down), .WAVEFORM_MODE(waveform_mode),
		.COMPARE_MATCH(compare_match), .WAVE_OUT(wave_out), .WAVE_CONNECT(wave_connect),
		.TEMP_HIGH(temp_high), .CAPTURE_CTRL(capture_ctrl));
	tmc_far_side u_far (.ref_clk(ref_clk), .wave_out(wave_out), .count_pin(count_pin),
		.compare_values(compare_values), .capture_value(capture_value));

	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;

	// Match pulses per channel, so tests compare counts, not moments
	always @(posedge ref_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (compare_match[i] === 1'h1) hits[i]++;
		end
	end
	////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	// One bus cycle; request held until waitrequest is low at an edge
	task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
			output logic [7:0] q);
		int i;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		// Waitrequest and read data are taken at the same rising edge
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'h0) break;
		end
		q = avs_readdata[7:0];
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		if (i == 20) begin
			err_count++;
			test_done();
		end
		@(negedge ref_clk);
	endtask : bus

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'h1, a, d, q);
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'h0, a, 8'h00, q);
		check({8'h00, q}, {8'h00, exp});
	endtask : rd
	////////////////////////////////////////
	// Reset values, reserved bits, mode code assembly
	task automatic t_regs();
		for (int i = 0; i < 6; i++) rd(10'h200 + 10'(4 * i), 8'h00);
		wr(10'h204, 8'hff);
		rd(10'h204, 8'hdf);
		check({14'h0, capture_ctrl}, 16'h0003);
		wr(10'h208, 8'h1f);
		rd(10'h208, 8'h00);
		rd(10'h3fc, 8'h00);
		for (int m = 0; m < 16; m++) begin
			wr(10'h204, {3'h0, 2'(m >> 2), 3'h0});
			wr(10'h200, {6'h00, 2'(m)});
			check({12'h0, waveform_mode}, 16'(m));
		end
		$display("register test done, mismatches %0d", err_count);
	endtask : t_regs

	// Two-byte counter access through the shared high byte
	task automatic t_access();
		wr(10'h204, 8'h00);
		wr(10'h200, 8'h00);
		wr(10'h214, 8'h12);
		check({8'h00, temp_high}, 16'h0012);
		check(count_value, 16'h0000);
		wr(10'h210, 8'h34);
		check(count_value, 16'h1234);
		wr(10'h214, 8'h77);
		rd(10'h210, 8'h34);
		rd(10'h214, 8'h12);
		rd(10'h211, 8'h00);
		$display("counter access test done, mismatches %0d", err_count);
	endtask : t_access

	// Forced matches in clear-on-match mode, then ignored in PWM
	task automatic t_force();
		int h;
		h = hits[0] + hits[1] + hits[2];
		wr(10'h204, 8'h08);
		wr(10'h200, 8'hd0);
		check({13'h0, wave_connect}, 16'h0006);
		wr(10'h208, 8'he0);
		check({14'h0, wave_out[2:1]}, 16'h0003);
		check(count_value, 16'h1234);
		wr(10'h208, 8'h40);
		check({15'h0, wave_out[1]}, 16'h0000);
		wr(10'h200, 8'ha0);
		wr(10'h208, 8'h80);
		check({15'h0, wave_out[2]}, 16'h0000);
		rd(10'h208, 8'h00);
		wr(10'h200, 8'hc3);
		wr(10'h204, 8'h18);
		wr(10'h208, 8'h80);
		check({15'h0, wave_out[2]}, 16'h0000);
		check(16'(hits[0] + hits[1] + hits[2] - h), 16'h0000);
		$display("force test done, mismatches %0d", err_count);
	endtask : t_force

	// Spacing of counter steps for each prescaler tap
	task automatic t_rates();
		int per[5] = '{1, 8, 64, 256, 1024};
		int p;
		int n;
		int last;
		logic [15:0] prev;
		wr(10'h200, 8'h00);
		for (int s = 0; s < 5; s++) begin
			wr(10'h204, 8'(s + 1));
			n = 0;
			p = 0;
			last = 0;
			prev = count_value;
			for (int c = 0; c < 3500 && n < 3; c++) begin
				@(negedge ref_clk);
				if (count_value !== prev) begin
					n++;
					if (n == 3) p = c - last;
					last = c;
					prev = count_value;
				end
			end
			check(16'(p), 16'(per[s]));
		end
		$display("prescaler test done, mismatches %0d", err_count);
	endtask : t_rates

	// Highest count reached in each mode but 0, 2, 3, D and F equals its top; phase modes turn down
	task automatic t_modes();
		logic [3:0] mt[11] = '{4'h1, 4'h4, 4'hc, 4'h5, 4'h6, 4'h7, 4'he, 4'h9, 4'ha, 4'hb, 4'h8};
		logic [15:0] tt[11] = '{16'h00ff, 16'h0040, 16'h0040, 16'h00ff, 16'h01ff, 16'h03ff,
			16'h0030, 16'h0040, 16'h0030, 16'h0040, 16'h0030};
		logic [10:0] ph = 11'b111_1000_0001;
		logic [15:0] t;
		logic [15:0] mx;
		logic        dn;
		logic        pd;
		for (int k = 0; k < 11; k++) begin
			t = tt[k] - 16'h0002;
			wr(10'h204, {3'h0, mt[k][3:2], 3'h0});
			wr(10'h200, {6'h00, mt[k][1:0]});
			wr(10'h214, t[15:8]);
			wr(10'h210, t[7:0]);
			wr(10'h204, {3'h0, mt[k][3:2], 3'h1});
			mx = 16'h0000;
			dn = 1'h0;
			pd = count_down;
			repeat (600) begin
				@(negedge ref_clk);
				if (count_value > mx) mx = count_value;
				if (count_down === 1'h1 && pd !== 1'h1) dn = 1'h1;
				pd = count_down;
			end
			check(mx, tt[k]);
			check({15'h0, dn}, {15'h0, ph[k]});
		end
		$display("mode test done, mismatches %0d", err_count);
	endtask : t_modes

	// A counter write on the fly hides the next match only
	task automatic t_block();
		int hb;
		int hc;
		wr(10'h204, 8'h00);
		wr(10'h200, 8'h00);
		wr(10'h214, 8'h00);
		wr(10'h210, 8'h1e);
		hb = hits[1];
		hc = hits[0];
		wr(10'h204, 8'h01);
		repeat (6) @(posedge ref_clk);
		wr(10'h214, 8'h00);
		wr(10'h210, 8'h20);
		repeat (20) @(posedge ref_clk);
		check(16'(hits[1] - hb), 16'h0001);
		check(16'(hits[0] - hc), 16'h0001);
		$display("write block test done, mismatches %0d", err_count);
	endtask : t_block

	// Pin edges counted on the chosen polarity
	task automatic t_ext();
		logic [15:0] b;
		for (int s = 7; s >= 6; s--) begin
			wr(10'h204, 8'(s));
			b = count_value;
			u_far.pulse_pin(3);
			repeat (4) @(posedge ref_clk);
			check(count_value, b + 16'h0003);
		end
		$display("external pin test done, mismatches %0d", err_count);
	endtask : t_ext
	////////////////////////////////////////
	// Main sequence after five reset cycles
	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'h0;
		t_regs();
		t_access();
		t_force();
		t_rates();
		t_modes();
		t_block();
		t_ext();
		test_done();
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge ref_clk);
		err_count++;
		test_done();
	end
endmodule : tmc_timer_test
`default_nettype wire
